/* File: hdl/scwp_top.sv */
// spi target front end: command framing, write latch, status and protection
module scwp_top
	import scwp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic nv_rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic hold_n,
	input wire logic wp_n,
	output logic miso,
	output logic miso_oe,
	output logic mem_rd,
	output logic mem_wr,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic spi_mode3,
	output logic cmd_event,
	output logic [7:0] cmd_code
);

	// ---------------------------------------------------------------
	// pin synchronisation and nonvolatile bits
	// ---------------------------------------------------------------
	scwp_pins_t pins_raw;
	scwp_pins_t pins;
	scwp_nv_t nv;
	scwp_core_t st;
	scwp_core_t next_st;

	assign pins_raw = '{sck: sck, cs_n: cs_n, mosi: mosi, hold_n: hold_n,
		wp_n: wp_n};

	scwp_sync #(
		.W($bits(scwp_pins_t)),
		.RST_VAL(PINS_IDLE)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.d(pins_raw),
		.q(pins)
	);

	scwp_nvbits u_nv (
		.core_clk(core_clk),
		.nv_rst(nv_rst),
		.wr(st.nv_wr),
		.din(st.nv_data),
		.q(nv)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------

	// true when the byte address falls in the block-protected range
	function automatic logic in_protected(input logic [1:0] bp,
		input logic [15:0] a);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			BP_NONE: hit = 1'b0;
			BP_QUARTER: hit = (a >= BP_QUARTER_BASE);
			BP_HALF: hit = (a >= BP_HALF_BASE);
			BP_ALL: hit = 1'b1;
		endcase
		return hit;
	endfunction

	// status byte as shifted out
	function automatic logic [7:0] status_byte(input scwp_nv_t n,
		input logic write_latch_flag);
		logic [7:0] s;
		s = STAT_FIXED;
		s[STAT_PIN_PROTECT_POS] = n.pin_protect_enable;
		s[STAT_BP_HI_POS] = n.block_protect_hi;
		s[STAT_BP_LO_POS] = n.block_protect_lo;
		s[STAT_LATCH_POS] = write_latch_flag;
		return s;
	endfunction

	// ---------------------------------------------------------------
	// command engine
	// ---------------------------------------------------------------
	logic holding;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic [7:0] rx;
	logic [15:0] addr_inc;
	logic sr_locked;

	// edge detection on synchronised pins; hold blocks every clock and select edge
	always_comb begin
		holding = ~pins.hold_n;
		cs_fall = ~holding & st.cs_prev_n & ~pins.cs_n;
		cs_rise = ~holding & ~st.cs_prev_n & pins.cs_n;
		sck_rise = ~holding & ~pins.cs_n & ~st.cs_prev_n
			& ~st.sck_prev & pins.sck;
		sck_fall = ~holding & ~pins.cs_n & ~st.cs_prev_n
			& st.sck_prev & ~pins.sck;
		rx = {st.rx_sh[6:0], pins.mosi};
		addr_inc = st.addr + ADDR_STEP;
		sr_locked = nv.pin_protect_enable & ~st.wp_lat;
	end

	// next-state logic of the whole front end
	always_comb begin
		next_st = st;
		next_st.mem.rd = 1'b0;
		next_st.mem.wr = 1'b0;
		next_st.nv_wr = 1'b0;
		next_st.cmd_event = 1'b0;
		next_st.rd_wait = st.mem.rd;
		// memory answers the cycle after the request is seen
		if (st.rd_wait) begin
			next_st.tx_buf = mem_rdata;
		end
		if (!holding) begin
			next_st.sck_prev = pins.sck;
			next_st.cs_prev_n = pins.cs_n;
		end
		if (cs_fall) begin
			// new frame: mode from clock level, protect pin latched
			next_st.state = ST_OP;
			next_st.mode3 = pins.sck;
			next_st.wp_lat = pins.wp_n;
			next_st.bit_cnt = BIT_FIRST;
			next_st.addr_lo = 1'b0;
			next_st.fast = 1'b0;
			next_st.is_write = 1'b0;
			next_st.write_class = 1'b0;
			next_st.driving = 1'b0;
		end else if (cs_rise) begin
			// frame end completes any write operation
			next_st.state = ST_IDLE;
			next_st.driving = 1'b0;
			if (st.write_class) begin
				next_st.write_latch_flag = 1'b0;
			end
		end else if (sck_rise) begin
			next_st.rx_sh = rx;
			next_st.bit_cnt = st.bit_cnt + 3'd1;
			if (st.bit_cnt == BIT_LAST) begin
				unique case (st.state)
					ST_OP: begin
						next_st.cmd_event = 1'b1;
						next_st.cmd_code = rx;
						next_st.state = ST_SKIP;
						unique case (rx)
							CMD_WRITE_ENABLE_SET: begin
								next_st.write_latch_flag = 1'b1;
							end
							CMD_WRITE_DISABLE: begin
								next_st.write_latch_flag = 1'b0;
							end
							CMD_STATUS_READ: begin
								next_st.state = ST_SR_RD;
								next_st.tx_buf = status_byte(nv, st.write_latch_flag);
							end
							CMD_STATUS_WRITE: begin
								next_st.state = ST_SR_WR;
								next_st.write_class = 1'b1;
							end
							CMD_MEM_READ: begin
								next_st.state = ST_ADDR;
							end
							CMD_FAST_READ: begin
								next_st.state = ST_ADDR;
								next_st.fast = 1'b1;
							end
							CMD_MEM_WRITE: begin
								next_st.state = ST_ADDR;
								next_st.is_write = 1'b1;
								next_st.write_class = 1'b1;
							end
							CMD_SLEEP, CMD_IDENTITY_READ,
							CMD_SERIAL_NUMBER_READ: begin
								next_st.state = ST_SKIP;
							end
							default: begin
								next_st.state = ST_SKIP;
							end
						endcase
					end
					ST_ADDR: begin
						if (!st.addr_lo) begin
							next_st.addr[15:8] = rx;
							next_st.addr_lo = 1'b1;
						end else begin
							next_st.addr[7:0] = rx;
							if (st.is_write) begin
								next_st.state = ST_WRITE;
							end else if (st.fast) begin
								next_st.state = ST_DUMMY;
							end else begin
								next_st.state = ST_READ;
								next_st.mem.rd = 1'b1;
								next_st.mem.addr = {st.addr[15:8], rx};
							end
						end
					end
					ST_DUMMY: begin
						// one byte of latency, input ignored
						next_st.state = ST_READ;
						next_st.mem.rd = 1'b1;
						next_st.mem.addr = st.addr;
					end
					ST_READ: begin
						// prefetch the following byte
						next_st.addr = addr_inc;
						next_st.mem.rd = 1'b1;
						next_st.mem.addr = addr_inc;
					end
					ST_WRITE: begin
						if (st.write_latch_flag && !in_protected({nv.block_protect_hi,
							nv.block_protect_lo}, st.addr)) begin
							next_st.mem.wr = 1'b1;
							next_st.mem.addr = st.addr;
							next_st.mem.wdata = rx;
						end
						next_st.addr = addr_inc;
					end
					ST_SR_WR: begin
						// latch flag bit of the data byte is not used
						if (st.write_latch_flag && !sr_locked) begin
							next_st.nv_wr = 1'b1;
							next_st.nv_data.pin_protect_enable =
								rx[STAT_PIN_PROTECT_POS];
							next_st.nv_data.block_protect_hi =
								rx[STAT_BP_HI_POS];
							next_st.nv_data.block_protect_lo =
								rx[STAT_BP_LO_POS];
						end
						next_st.state = ST_SKIP;
					end
					ST_SR_RD, ST_SKIP, ST_IDLE: begin
						next_st.state = st.state;
					end
					default: begin
						next_st.state = ST_SKIP;
					end
				endcase
			end
		end else if (sck_fall) begin
			// output shifts only in read phases
			if (st.state == ST_READ || st.state == ST_SR_RD) begin
				next_st.driving = 1'b1;
				if (st.bit_cnt == BIT_FIRST) begin
					next_st.miso = st.tx_buf[7];
					next_st.tx_sh = {st.tx_buf[6:0], 1'b0};
				end else begin
					next_st.miso = st.tx_sh[7];
					next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
				end
			end
		end
		// pin drive: off under hold and while deselected
		next_st.miso_oe = next_st.driving & pins.hold_n
			& ~pins.cs_n;
	end

	// state register; latch clear at power-up
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= CORE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign miso = st.miso;
	assign miso_oe = st.miso_oe;
	assign mem_rd = st.mem.rd;
	assign mem_wr = st.mem.wr;
	assign mem_addr = st.mem.addr;
	assign mem_wdata = st.mem.wdata;
	assign spi_mode3 = st.mode3;
	assign cmd_event = st.cmd_event;
	assign cmd_code = st.cmd_code;

endmodule

/* File: shared/scwp_pkg.sv */
// constants, types and state layout for the spi command and write-protect block
//
// Contract
// - only modes 0 and 3; mode taken from clock level at each select fall
// - input sampled on clock rise, output changed only on clock fall
// - all transfers are eight-bit groups, most significant bit first
// - first byte after select is the op-code, then address, then data
// - memory commands carry two address bytes forming a 16-bit address
// - op-code 06h sets the write latch; no further bytes follow
// - op-code 04h clears the write latch, blocking all writes
// - after op-code 05h one status byte is shifted out
// - after op-code 01h next byte loads writable status bits unless protected
// - 03h memory read, 0Bh fast read, 02h memory write, each with address
// - B9h sleep, 9Fh identity, C3h serial number; ten op-codes in all
// - write latch is clear after power-up
// - write latch clears automatically when any write operation completes
// - status write never alters the latch flag bit
// - status reads protect-enable, 1, 0, 0, block bits, latch flag, 0
// - block-protect bits are kept in nonvolatile storage
// - block bits 00 none, 01 C000h-FFFFh, 10 8000h-FFFFh, 11 all
// - protect pin ignored when enable is 0; with enable and pin low, no status write
// - memory write needs latch set and address outside protected range only
// - select high: ignore clock and input, output high impedance
// - hold low: suspend, ignore clock and select, output high impedance
// - sequential access increments address per byte, wrapping FFFFh to 0000h
package scwp_pkg;

	// ---------------------------------------------------------------
	// op-codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE_SET = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_MEM_READ = 8'h03;
	localparam logic [7:0] CMD_FAST_READ = 8'h0b;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
	localparam logic [7:0] CMD_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_IDENTITY_READ = 8'h9f;
	localparam logic [7:0] CMD_SERIAL_NUMBER_READ = 8'hc3;

	// ---------------------------------------------------------------
	// status byte layout
	// ---------------------------------------------------------------
	localparam int STAT_PIN_PROTECT_POS = 7;
	localparam int STAT_BP_HI_POS = 3;
	localparam int STAT_BP_LO_POS = 2;
	localparam int STAT_LATCH_POS = 1;
	localparam logic [7:0] STAT_FIXED = 8'h40; // bit 6 one, 5/4/0 zero

	// ---------------------------------------------------------------
	// block protection ranges
	// ---------------------------------------------------------------
	localparam logic [1:0] BP_NONE = 2'b00;
	localparam logic [1:0] BP_QUARTER = 2'b01;
	localparam logic [1:0] BP_HALF = 2'b10;
	localparam logic [1:0] BP_ALL = 2'b11;
	localparam logic [15:0] BP_QUARTER_BASE = 16'hc000;
	localparam logic [15:0] BP_HALF_BASE = 16'h8000;

	// ---------------------------------------------------------------
	// counts
	// ---------------------------------------------------------------
	localparam logic [2:0] BIT_LAST = 3'd7;
	localparam logic [2:0] BIT_FIRST = 3'd0;
	localparam logic [15:0] ADDR_STEP = 16'h0001;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
		logic hold_n;
		logic wp_n;
	} scwp_pins_t;

	typedef struct packed {
		logic pin_protect_enable;
		logic block_protect_hi;
		logic block_protect_lo;
	} scwp_nv_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} scwp_mem_t;

	typedef enum logic [8:0] {
		ST_IDLE = 9'b0_0000_0001,
		ST_OP = 9'b0_0000_0010,
		ST_ADDR = 9'b0_0000_0100,
		ST_DUMMY = 9'b0_0000_1000,
		ST_READ = 9'b0_0001_0000,
		ST_WRITE = 9'b0_0010_0000,
		ST_SR_RD = 9'b0_0100_0000,
		ST_SR_WR = 9'b0_1000_0000,
		ST_SKIP = 9'b1_0000_0000
	} scwp_phase_t;

	typedef struct packed {
		scwp_phase_t state;
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [7:0] tx_buf;
		logic [15:0] addr;
		logic addr_lo;
		logic fast;
		logic is_write;
		logic write_class;
		logic mode3;
		logic wp_lat;
		logic sck_prev;
		logic cs_prev_n;
		logic write_latch_flag;
		logic rd_wait;
		logic driving;
		logic miso;
		logic miso_oe;
		scwp_mem_t mem;
		logic nv_wr;
		scwp_nv_t nv_data;
		logic cmd_event;
		logic [7:0] cmd_code;
	} scwp_core_t;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam scwp_pins_t PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0,
		hold_n: 1'b1, wp_n: 1'b1};
	localparam scwp_nv_t NV_RESET = '{default: 1'b0};
	localparam scwp_core_t CORE_RESET = '{state: ST_IDLE, cs_prev_n: 1'b1,
		wp_lat: 1'b1, default: '0};

endpackage

/* File: hdl/scwp_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
module scwp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} scwp_sync_t;

	scwp_sync_t st;
	scwp_sync_t next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st.meta = d;
		next_st.sync = st.meta;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '{meta: RST_VAL, sync: RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.sync;

endmodule

/* File: hdl/scwp_nvbits.sv */
// nonvolatile protection bits, cleared only by their own reset
module scwp_nvbits
	import scwp_pkg::*;
(
	input wire logic core_clk,
	input wire logic nv_rst,
	input wire logic wr,
	input wire scwp_nv_t din,
	output scwp_nv_t q
);

	scwp_nv_t st;
	scwp_nv_t next_st;

	// keep value across power-up resets; only a write changes it
	always_comb begin
		next_st = st;
		if (wr) begin
			next_st = din;
		end
	end

	always_ff @(posedge core_clk or posedge nv_rst) begin
		if (nv_rst) begin
			st <= NV_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign q = st;

endmodule

/* File: tb/scwp_props.sv */
// assertions on the pins and memory strobes of the spi target
module scwp_props
	import scwp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic spi_mode3,
	input wire logic cmd_event,
	input wire logic [7:0] cmd_code
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------
	// pin level rules
	// ----------------------------------------------------------
	sel_idle_off_a: assert property (cs_n [*4] |->
		!miso_oe && !mem_wr && !mem_rd && !cmd_event)
		else $error("activity while deselected");
	hold_off_a: assert property (!hold_n [*4] |-> !miso_oe)
		else $error("output driven during hold");
	oe_needs_sel_a: assert property ($rose(miso_oe) |-> !cs_n && hold_n)
		else $error("output enabled outside a frame");
	miso_on_fall_a: assert property ($changed(miso) && miso_oe &&
		$past(miso_oe) |-> !$past(sck, 3))
		else $error("output moved away from a clock fall");
	mode_pick_a: assert property ($fell(cs_n) |-> ##4 spi_mode3 == sck)
		else $error("mode not taken from clock at select fall");
	mode_hold_a: assert property (!cs_n [*6] |-> $stable(spi_mode3))
		else $error("mode changed inside a frame");

	// ----------------------------------------------------------
	// byte framing rules
	// ----------------------------------------------------------
	wr_pulse_a: assert property (mem_wr |=> !mem_wr [*8])
		else $error("write strobes closer than a byte");
	op_once_a: assert property (cmd_event |=> !cmd_event [*8])
		else $error("second op-code too soon");
	quiet_op_a: assert property (cmd_event && cmd_code != CMD_STATUS_READ
		|=> (!miso_oe && !mem_wr) [*8])
		else $error("action right after op-code");
endmodule

bind scwp_top scwp_props P (.core_clk(core_clk), .rst(rst), .sck(sck),
	.cs_n(cs_n), .hold_n(hold_n), .miso(miso), .miso_oe(miso_oe),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .spi_mode3(spi_mode3),
	.cmd_event(cmd_event), .cmd_code(cmd_code));

/* File: tb/scwp_spi_master.sv */
// spi bus master model driving the target pins
module scwp_spi_master (
	output logic sck,
	output logic cs_n,
	output logic mosi,
	output logic hold_n,
	input wire logic miso,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	int hold_at = -1;
	logic hold_oe = 1'b1;

	// pins idle: deselected, clock still
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		hold_n = 1'b1;
	end

	// one frame: send tx, clock n more bytes, collect every byte
	task automatic run(input bit m3, input logic [7:0] tx[$], input int n,
		output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		sck = m3;
		#24;
		cs_n = 1'b0;
		#24;
		for (int k = 0; k < tx.size() + n; k++) begin
			b = (k < tx.size()) ? tx[k] : 8'h00;
			for (int i = 7; i >= 0; i--) begin
				sck = 1'b0;
				mosi = b[i];
				if (k == hold_at && i == 3) begin
					hold_n = 1'b0;
					#200;
					hold_oe = miso_oe;
					hold_n = 1'b1;
					#200;
				end
				#24;
				sck = 1'b1;
				b[i] = miso_oe ? miso : 1'bx;
				#24;
			end
			rx.push_back(b);
		end
		sck = m3;
		#24;
		cs_n = 1'b1;
		mosi = ~mosi;
		#48;
	endtask
endmodule

/* File: tb/testbench.sv */
// testbench for the spi command and write-protect block
module testbench
	import scwp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic nv_rst = 1'b1;
	logic wp_n = 1'b1;
	logic sck, cs_n, mosi, hold_n, miso, miso_oe, mem_rd, mem_wr;
	logic spi_mode3, cmd_event;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, cmd_code;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] mem [0:65535];
	logic [7:0] em [0:65535];
	logic [7:0] rx[$];
	logic [7:0] ops[4] = '{CMD_SLEEP, CMD_IDENTITY_READ,
		CMD_SERIAL_NUMBER_READ, 8'hff};
	logic [15:0] ta[3] = '{16'h7fff, 16'hbfff, 16'hffff};
	logic [1:0] bp = 2'b00;
	bit m3 = 1'b0;
	int errors = 0;
	int num_checks = 0;

	always #2 core_clk = ~core_clk;

	// memory with one registered read stage
	always @(posedge core_clk) begin
		if (mem_rd)
			mem_rdata <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end

	scwp_top DUT (.core_clk(core_clk), .rst(rst), .nv_rst(nv_rst),
		.sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n),
		.miso(miso), .miso_oe(miso_oe), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.spi_mode3(spi_mode3), .cmd_event(cmd_event), .cmd_code(cmd_code));
	scwp_spi_master M (.sck(sck), .cs_n(cs_n), .mosi(mosi),
		.hold_n(hold_n), .miso(miso), .miso_oe(miso_oe));

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction

	// address inside the range that the block bits guard
	function automatic bit prot(input logic [15:0] a);
		return bp == 2'b11 || (bp == 2'b10 && a[15]) ||
			(bp == 2'b01 && a[15:14] == 2'b11);
	endfunction

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// one frame, then op-code, mode and idle output checked
	task automatic xfer(input logic [7:0] tx[$], input int n);
		M.run(m3, tx, n, rx);
		chk("op-code", tx[0], cmd_code);
		chk("mode", {7'h00, m3}, {7'h00, spi_mode3});
		chk("idle enable", 8'h00, {7'h00, miso_oe});
	endtask

	task automatic write_enable_set_cmd();
		xfer({CMD_WRITE_ENABLE_SET}, 0);
	endtask

	task automatic stat(input logic [7:0] exp);
		xfer({CMD_STATUS_READ}, 1);
		chk("status", exp, rx[1]);
	endtask

	task automatic status_write_cmd(input logic [7:0] v);
		write_enable_set_cmd();
		xfer({CMD_STATUS_WRITE, v}, 0);
	endtask

	// two bytes from a; shadow follows only where a write may land
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit en);
		logic [15:0] b;
		b = a + 16'h0001;
		if (en)
			write_enable_set_cmd();
		xfer({CMD_MEM_WRITE, a[15:8], a[7:0], d, ~d}, 0);
		if (en && !prot(a))
			em[a] = d;
		if (en && !prot(b))
			em[b] = ~d;
	endtask

	task automatic rd(input logic [15:0] a, input bit fast);
		if (fast)
			xfer({CMD_FAST_READ, a[15:8], a[7:0], 8'h00}, 2);
		else
			xfer({CMD_MEM_READ, a[15:8], a[7:0]}, 2);
		chk("read data", em[a], rx[rx.size() - 2]);
		chk("next data", em[a + 16'h0001], rx[rx.size() - 1]);
	endtask

	task automatic close_out();
		$display("checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = pat(i[15:0]);
			em[i] = pat(i[15:0]);
		end
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'b0;
		nv_rst = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		stat(8'h40);
		wr(16'h0010, 8'h11, 1'b0);
		rd(16'h0010, 1'b0);
		m3 = 1'b1;
		write_enable_set_cmd();
		stat(8'h42);
		xfer({CMD_WRITE_DISABLE}, 0);
		stat(8'h40);
		wr(16'h0010, 8'h11, 1'b0);
		m3 = 1'b0;
		wr(16'hffff, 8'ha1, 1'b1);
		stat(8'h40);
		rd(16'hffff, 1'b0);
		rd(16'hfffe, 1'b1);
		// every block setting against every range boundary
		for (int p = 0; p < 4; p++) begin
			status_write_cmd({4'h0, p[1:0], 2'b11});
			bp = p[1:0];
			stat({4'h4, bp, 2'b00});
			foreach (ta[k]) begin
				wr(ta[k], {p[3:0], k[3:0]}, 1'b1);
				rd(ta[k], 1'b0);
			end
		end
		// protect pin only matters once its enable is set
		@(posedge core_clk);
		#1;
		wp_n = 1'b0;
		status_write_cmd(8'h84);
		bp = 2'b01;
		stat(8'hc4);
		wr(16'h0020, 8'h5a, 1'b1);
		rd(16'h0020, 1'b0);
		status_write_cmd(8'h00);
		stat(8'hc4);
		@(posedge core_clk);
		#1;
		wp_n = 1'b1;
		status_write_cmd(8'h00);
		bp = 2'b00;
		stat(8'h40);
		// op-codes with no output here, and one undefined
		foreach (ops[k]) begin
			xfer({ops[k], 8'h00}, 1);
			chk("no output", 8'hxx, rx[2]);
		end
		// hold in mid-byte suspends a status read
		write_enable_set_cmd();
		M.hold_at = 1;
		stat(8'h42);
		M.hold_at = -1;
		chk("hold enable", 8'h00, {7'h00, M.hold_oe});
		close_out();
	end

	// hang guard
	initial begin
		repeat (90000) @(posedge core_clk);
		errors++;
		close_out();
	end
endmodule
